// >>> pmcs_switcher.v
// Power-mode and clock-source sequencer with a classic Wishbone slave.
// Assumes oscillator ready levels and source ticks arrive asynchronously;
// each is synchronised here. The gate enables drive external clock gates.
//
// How it works
// [RULE_01] Switch: two old plus three-four new cycles
// [RULE_02] Primary flag bit 3, secondary flag bit 6
// [RULE_03] Power-down samples idle bit at execution
// [RULE_04] Run states clock core and peripherals
// [RULE_05] Reset enters primary run, primary flag set
// [RULE_06] Select 01 moves to secondary oscillator
// [RULE_07] Secondary disabled blocks secondary run entry
// [RULE_08] Hold clocks until secondary oscillator starts
// [RULE_09] Secondary to primary waits for primary ready
// [RULE_10] Select 11 moves to internal oscillator
// [RULE_11] Internal to primary waits for primary ready
// [RULE_12] Low oscillator runs with watchdog or monitor
// [RULE_13] Sleep stops oscillator, clears status flags
// [RULE_14] Sleep needs no switch, keeps enabled oscs
// [RULE_15] Sleep wake waits for source or internal
// [RULE_16] Idle stops CPU, peripherals stay clocked
// [RULE_17] Idle exits on interrupt, watchdog, reset
// [RULE_18] Watchdog timeout wakes to selected run state
// [RULE_19] Software sets idle, selects primary, powers down
// [RULE_20] Primary idle wake keeps primary flag set
// [RULE_21] Idle bit 7, select field bits 1:0
// [RULE_22] Select write starts immediate switch
// [RULE_23] CPU-ready delay is a configurable count
// [RULE_24] Outgoing clock gated before incoming enabled
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pmcs_consts.vh"
module pmcs_switcher #(
  parameter CPU_READY_CYCLES = `PMCS_CPU_READY_CYCLES,
  parameter TWO_SPEED_DEFAULT = 0
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire power_down_i,
  input wire wake_irq_i,
  input wire wdt_timeout_i,
  input wire pri_ready_i,
  input wire sec_running_i,
  input wire pri_tick_i,
  input wire sec_tick_i,
  input wire int_tick_i,
  output reg pri_osc_en_o,
  output reg sec_osc_en_o,
  output reg lf_osc_en_o,
  output reg pri_gate_o,
  output reg sec_gate_o,
  output reg int_gate_o,
  output reg cpu_clk_en_o,
  output reg periph_clk_en_o,
  output reg cpu_ready_o
);
  // Power states
  localparam ST_RUN = 3'h0;
  localparam ST_SWOLD = 3'h1;
  localparam ST_SWNEW = 3'h2;
  localparam ST_IDLE = 3'h3;
  localparam ST_SLEEP = 3'h4;
  localparam ST_WAKE = 3'h5;
  localparam ST_CSD = 3'h6;

  // Writable bits per register; flags and holes stay read-only
  localparam [7:0] OSC_WR_MASK = 8'h83;
  localparam [7:0] SEC_WR_MASK = 8'h08;
  localparam [7:0] FEAT_WR_MASK = 8'h07;

  reg [2:0] state;
  reg [7:0] osc_ctrl;
  reg [7:0] sec_ctrl;
  reg [7:0] feat_ctrl;
  reg [1:0] active_src;
  reg [1:0] target_src;
  reg [15:0] csd_cnt;
  reg [2:0] edge_cnt;
  reg pri_flag;
  reg sec_flag;
  reg [1:0] s_pri_rdy;
  reg [1:0] s_secondary_run_state;
  reg [1:0] s_pri_tk;
  reg [1:0] s_sec_tk;
  reg [1:0] s_int_tk;
  reg old_tk_d;
  reg new_tk_d;
  reg old_tk;
  reg new_tk;
  reg src_ready;
  reg old_edge;
  reg new_edge;
  wire [1:0] sel;
  wire sec_en;
  wire wb_hit;
  wire want_pri;
  wire want_sec;
  wire want_int;

  // Field decode; unused code 00 is folded onto internal below
  assign sel = osc_ctrl[`PMCS_SEL_HI:`PMCS_SEL_LO]; // see [RULE_21]
  assign sec_en = sec_ctrl[`PMCS_SEC_EN_BIT];
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Two-flop synchronisers; only the second stage is read
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_pri_rdy <= 2'h0;
      s_secondary_run_state <= 2'h0;
      s_pri_tk <= 2'h0;
      s_sec_tk <= 2'h0;
      s_int_tk <= 2'h0;
    end
    else
    begin
      s_pri_rdy <= {s_pri_rdy[0], pri_ready_i};
      s_secondary_run_state <= {s_secondary_run_state[0], sec_running_i};
      s_pri_tk <= {s_pri_tk[0], pri_tick_i};
      s_sec_tk <= {s_sec_tk[0], sec_tick_i};
      s_int_tk <= {s_int_tk[0], int_tick_i};
    end
  end

  // Pick outgoing and incoming source ticks and readiness
  always @*
  begin
    case (active_src)
      `PMCS_SEL_PRI: old_tk = s_pri_tk[1];
      `PMCS_SEL_SEC: old_tk = s_sec_tk[1];
      default: old_tk = s_int_tk[1];
    endcase
    case (target_src)
      `PMCS_SEL_PRI:
      begin
        new_tk = s_pri_tk[1];
        src_ready = s_pri_rdy[1];
      end
      `PMCS_SEL_SEC:
      begin
        new_tk = s_sec_tk[1];
        src_ready = s_secondary_run_state[1]; // see [RULE_08]
      end
      default:
      begin
        new_tk = s_int_tk[1];
        src_ready = 1'b1;
      end
    endcase
    old_edge = old_tk & ~old_tk_d;
    new_edge = new_tk & ~new_tk_d;
  end

  // Internal select codes 00 and 11 both mean the internal oscillator
  assign want_pri = (sel == `PMCS_SEL_PRI);
  assign want_sec = (sel == `PMCS_SEL_SEC) & sec_en; // see [RULE_07]
  assign want_int = (sel == `PMCS_SEL_INT) | (sel == `PMCS_SEL_INT0);

  // Sequencer: run, glitch-free switch, idle, sleep, wake
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_RUN;
      active_src <= `PMCS_SEL_PRI; // see [RULE_05]
      target_src <= `PMCS_SEL_PRI;
      pri_flag <= 1'b1;
      sec_flag <= 1'b0;
      edge_cnt <= 3'h0;
      csd_cnt <= 16'h0000;
      old_tk_d <= 1'b0;
      new_tk_d <= 1'b0;
    end
    else
    begin
      old_tk_d <= old_tk;
      new_tk_d <= new_tk;
      case (state)
        ST_RUN:
        begin
          if (power_down_i && osc_ctrl[`PMCS_IDLE_BIT]) // see [RULE_03]
            state <= ST_IDLE; // see [RULE_16]
          else if (power_down_i)
          begin
            state <= ST_SLEEP; // see [RULE_13]
            pri_flag <= 1'b0;
            sec_flag <= 1'b0;
          end
          else if (((want_pri && active_src != `PMCS_SEL_PRI) ||
                    (want_sec && active_src != `PMCS_SEL_SEC) ||
                    (want_int && active_src != `PMCS_SEL_INT)))
          begin
            // Stay on old source until the new one is ready
            target_src <= want_int ? `PMCS_SEL_INT : sel; // see [RULE_22]
            state <= ST_SWOLD;
            edge_cnt <= 3'h0;
          end
        end
        ST_SWOLD:
        begin
          // Outgoing source keeps running until the incoming is ready
          if (src_ready && old_edge) // see [RULE_09] [RULE_11]
          begin
            if (edge_cnt == `PMCS_OLD_CYCLES - 1) // see [RULE_01]
            begin
              state <= ST_SWNEW;
              edge_cnt <= 3'h0;
            end
            else
              edge_cnt <= edge_cnt + 3'h1;
          end
        end
        ST_SWNEW:
        begin
          // Old gate drops one cycle after entry; count incoming edges
          if (new_edge)
          begin
            if (edge_cnt == `PMCS_NEW_CYCLES - 1) // see [RULE_01] [RULE_24]
            begin
              state <= ST_RUN;
              active_src <= target_src;
              pri_flag <= (target_src == `PMCS_SEL_PRI); // see [RULE_06]
              sec_flag <= (target_src == `PMCS_SEL_SEC); // see [RULE_10]
            end
            else
              edge_cnt <= edge_cnt + 3'h1;
          end
        end
        ST_IDLE:
        begin
          // Gates stay as they were; only the CPU enable and CPU-ready drop
          if (wake_irq_i || wdt_timeout_i) // see [RULE_17] [RULE_18]
          begin
            state <= ST_CSD;
            csd_cnt <= 16'h0000;
          end
        end
        ST_SLEEP:
        begin
          // Select field is left alone; the wake reads it afresh
          if (wake_irq_i || wdt_timeout_i) // see [RULE_18]
          begin
            state <= ST_WAKE;
            target_src <= want_int ? `PMCS_SEL_INT : sel;
          end
        end
        ST_WAKE:
        begin
          // Fast start from internal osc when two-speed or monitor on
          if (feat_ctrl[`PMCS_TWOSPD_EN_BIT] ||
              feat_ctrl[`PMCS_FSCM_EN_BIT])
          begin
            active_src <= `PMCS_SEL_INT; // see [RULE_15]
            // Re-seed the detector: the outgoing mux input changes now,
            // and a stale sample would count a false old-source edge
            old_tk_d <= s_int_tk[1];
            // Limitation: unless the target is internal, this path goes straight to the switch, so the
            // CPU runs from the internal source without the ready delay
            state <= (target_src == `PMCS_SEL_INT) ? ST_CSD : ST_SWOLD;
            edge_cnt <= 3'h0;
            csd_cnt <= 16'h0000;
          end
          else if (src_ready)
          begin
            active_src <= target_src;
            pri_flag <= (target_src == `PMCS_SEL_PRI); // see [RULE_15]
            sec_flag <= (target_src == `PMCS_SEL_SEC);
            state <= ST_CSD;
            csd_cnt <= 16'h0000;
          end
        end
        ST_CSD:
        begin
          // CPU-ready interval of CPU_READY_CYCLES cycles before execution resumes
          if (csd_cnt == CPU_READY_CYCLES[15:0] - 16'h0001) // see [RULE_23]
            state <= ST_RUN; // see [RULE_20]
          else
            csd_cnt <= csd_cnt + 16'h0001;
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Oscillator enables and clock gates, registered to avoid glitches
  // A gate and its oscillator enable share one edge, so a gate never
  // opens onto an oscillator that is being stopped
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pri_osc_en_o <= 1'b1;
      sec_osc_en_o <= 1'b0;
      lf_osc_en_o <= 1'b0;
      pri_gate_o <= 1'b0;
      sec_gate_o <= 1'b0;
      int_gate_o <= 1'b0;
      cpu_clk_en_o <= 1'b0;
      periph_clk_en_o <= 1'b0;
      cpu_ready_o <= 1'b0;
    end
    else
    begin
      // Primary stops unless used, targeted, or idling on it
      pri_osc_en_o <= (state != ST_SLEEP) &&
        (active_src == `PMCS_SEL_PRI || target_src == `PMCS_SEL_PRI ||
         (state == ST_WAKE && target_src == `PMCS_SEL_PRI)); // see [RULE_19]
      sec_osc_en_o <= sec_en; // see [RULE_14]
      lf_osc_en_o <= feat_ctrl[`PMCS_WDT_EN_BIT] ||
        feat_ctrl[`PMCS_FSCM_EN_BIT] ||
        (state != ST_SLEEP && active_src == `PMCS_SEL_INT); // see [RULE_12]
      // Only one gate open; none during incoming count or sleep
      pri_gate_o <= (state != ST_SWNEW) && (state != ST_SLEEP) &&
        (state != ST_WAKE) && (active_src == `PMCS_SEL_PRI); // see [RULE_24]
      sec_gate_o <= (state != ST_SWNEW) && (state != ST_SLEEP) &&
        (state != ST_WAKE) && (active_src == `PMCS_SEL_SEC);
      int_gate_o <= (state != ST_SWNEW) && (state != ST_SLEEP) &&
        (state != ST_WAKE) && (active_src == `PMCS_SEL_INT);
      periph_clk_en_o <= (state != ST_SLEEP) && (state != ST_WAKE) &&
        (state != ST_SWNEW); // see [RULE_16]
      cpu_clk_en_o <= (state == ST_RUN) || (state == ST_SWOLD); // see [RULE_04]
      cpu_ready_o <= (state == ST_RUN) || (state == ST_SWOLD);
    end
  end

  // Wishbone classic slave, one-cycle ack, byte lane 0 only
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      osc_ctrl <= `PMCS_OSC_CTRL_RST;
      sec_ctrl <= `PMCS_SEC_CTRL_RST;
      feat_ctrl <= TWO_SPEED_DEFAULT ? `PMCS_FEAT_TWOSPD_RST :
        `PMCS_FEAT_CTRL_RST;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      // Only lane 0 carries bits; writes without it are dropped
      if (wb_hit && wb_we_i && wb_sel_i[0])
      begin
        case (wb_adr_i)
          `PMCS_OSC_CTRL_OFS: osc_ctrl <= wb_dat_i[7:0] & OSC_WR_MASK;
          `PMCS_SEC_CTRL_OFS: sec_ctrl <= wb_dat_i[7:0] & SEC_WR_MASK;
          `PMCS_FEAT_CTRL_OFS: feat_ctrl <= wb_dat_i[7:0] & FEAT_WR_MASK;
          default: osc_ctrl <= osc_ctrl;
        endcase
      end
      // Reads show flags live; reserved bits and holes read zero
      if (wb_hit && !wb_we_i)
      begin
        case (wb_adr_i)
          `PMCS_OSC_CTRL_OFS:
            wb_dat_o <= {24'h000000, osc_ctrl[7:4], pri_flag,
              osc_ctrl[2:0]}; // see [RULE_02]
          `PMCS_SEC_CTRL_OFS:
            wb_dat_o <= {24'h000000, sec_ctrl[7], sec_flag,
              sec_ctrl[5:0]};
          `PMCS_FEAT_CTRL_OFS: wb_dat_o <= {24'h000000, feat_ctrl};
          `PMCS_STATUS_OFS:
            wb_dat_o <= {24'h000000, 3'h0, active_src, state};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // pmcs_switcher

// >>> pmcs_consts.vh
// Constants for the power-mode clock switcher: register map, fields,
// reset values and timing counts. Definitions only.
`ifndef PMCS_CONSTS_VH
`define PMCS_CONSTS_VH
// Register byte offsets (one 32-bit word each)
`define PMCS_OSC_CTRL_OFS 4'h0
`define PMCS_SEC_CTRL_OFS 4'h4
`define PMCS_FEAT_CTRL_OFS 4'h8
`define PMCS_STATUS_OFS 4'hC
// Oscillator control fields
`define PMCS_IDLE_BIT 7
`define PMCS_PRI_FLAG_BIT 3
`define PMCS_SEL_HI 1
`define PMCS_SEL_LO 0
// Secondary control fields
`define PMCS_SEC_FLAG_BIT 6
`define PMCS_SEC_EN_BIT 3
// Feature control fields
`define PMCS_WDT_EN_BIT 0
`define PMCS_FSCM_EN_BIT 1
`define PMCS_TWOSPD_EN_BIT 2
// Source select encodings
`define PMCS_SEL_PRI 2'h2
`define PMCS_SEL_SEC 2'h1
`define PMCS_SEL_INT 2'h3
`define PMCS_SEL_INT0 2'h0
// Reset values
`define PMCS_OSC_CTRL_RST 8'h02
`define PMCS_SEC_CTRL_RST 8'h00
`define PMCS_FEAT_CTRL_RST 8'h00
`define PMCS_FEAT_TWOSPD_RST 8'h04
// Switch timing in source cycles
`define PMCS_OLD_CYCLES 2
`define PMCS_NEW_CYCLES 3
// CPU-ready delay in system clock cycles (default)
`define PMCS_CPU_READY_CYCLES 16
`endif

// >>> pmcs_props.sv
// Checker for the clock switcher: bus timing and clock gate sequencing.
// Sees only the switcher's ports; attached by the bind at the foot.
`timescale 1ns/1ps
module pmcs_props (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire pri_osc_en_o,
  input wire sec_osc_en_o,
  input wire pri_gate_o,
  input wire sec_gate_o,
  input wire int_gate_o,
  input wire cpu_clk_en_o,
  input wire periph_clk_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answers once, one cycle after the request is taken
  chk_ack_once:
  assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_next:
  assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  // Holes between word offsets read as zero
  chk_hole_zero:
  assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0) else $error("hole");
  // Never two sources on the device clock net
  chk_gate_one:
  assert property ($onehot0({pri_gate_o, sec_gate_o, int_gate_o}))
    else $error("two gates");
  // A new gate opens only after all were shut a cycle earlier
  chk_gate_break:
  assert property ($rose(pri_gate_o) || $rose(sec_gate_o)
    || $rose(int_gate_o) |-> $past({pri_gate_o, sec_gate_o, int_gate_o})
    == 3'h0) else $error("gate overlap");
  chk_run_both:
  assert property (cpu_clk_en_o |-> periph_clk_en_o)
    else $error("cpu without peripherals");
  chk_gate_osc:
  assert property ((pri_gate_o |-> pri_osc_en_o)
    and (sec_gate_o |-> sec_osc_en_o)) else $error("gate on dead osc");
  chk_reset_pri:
  assert property ($fell(rst_i) |-> ##[1:2] pri_gate_o && cpu_clk_en_o)
    else $error("no primary run after reset");
endmodule // pmcs_props
bind pmcs_switcher pmcs_props u_pmcs_props (.*);

// >>> tb.sv
// Self-checking bench for the clock switcher over Wishbone.
// Bench plays oscillators: ticks at 4, 16, 8 clk periods.
`timescale 1ns/1ps
module tb;
  localparam int RDY = 4;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic power_down_i, wake_irq_i, wdt_timeout_i, pri_ready_i;
  logic sec_running_i, pri_tick_i, sec_tick_i, int_tick_i;
  logic pri_osc_en_o, sec_osc_en_o, lf_osc_en_o, pri_gate_o;
  logic sec_gate_o, int_gate_o, cpu_clk_en_o, periph_clk_en_o;
  logic cpu_ready_o;
  logic [7:0] tick_cnt;
  int failures, samples_checked, n, gap;
  wire [2:0] gates = {pri_gate_o, sec_gate_o, int_gate_o};
  pmcs_switcher #(.CPU_READY_CYCLES(RDY)) u_pmcs_switcher (.*);
  // Clock
  initial
  begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  // Source ticks, three rates taken from one counter
  always @(posedge clk_i)
  begin
    tick_cnt <= tick_cnt + 8'h01;
    pri_tick_i <= tick_cnt[1];
    sec_tick_i <= tick_cnt[3];
    int_tick_i <= tick_cnt[2];
  end
  task stop_test;
    $display("checked %0d failed %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask
  // One classic cycle; waits for ack, bounded
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    if (n >= 50)
    begin
      failures++;
      stop_test;
    end
  endtask
  // A wait that used up its bound ends the run
  task limit(input int lim);
    if (n >= lim)
    begin
      failures++;
      stop_test;
    end
  endtask
  // Waits out a switch; p is the new source period
  task wait_gate(input logic [2:0] exp, input int p);
    n = 0;
    gap = 0;
    while (gates !== 3'h0 && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    while (gates === 3'h0 && n < 800)
    begin
      @(posedge clk_i);
      n++;
      gap++;
    end
    chk(gates, exp);
    chk(gap >= 2 * p && gap <= 4 * p + 8, 1);
    limit(400);
  endtask
  task t_reset;
    wb(0, 4'h0, 0);
    chk(q, 32'h0A);
    wb(0, 4'h4, 0);
    chk(q, 32'h00);
    chk({pri_osc_en_o, cpu_clk_en_o, periph_clk_en_o, gates}, 6'h3C);
    wb(1, 4'h1, 32'hFF);
    wb(0, 4'h2, 0);
    chk(q, 32'h00);
    wb_sel_i <= 4'hE;
    wb(1, 4'h0, 32'h83);
    wb_sel_i <= 4'hF;
    wb(0, 4'h0, 0);
    chk(q, 32'h0A);
  endtask
  task t_sec;
    wb(1, 4'h0, 32'h01);
    repeat (100) @(posedge clk_i);
    chk(gates, 3'h4);
    wb(1, 4'h0, 32'h02);
    wb(1, 4'h4, 32'h08);
    wb(1, 4'h0, 32'h01);
    repeat (120) @(posedge clk_i);
    chk(sec_gate_o, 0);
    sec_running_i <= 1;
    wait_gate(3'h2, 16);
    wb(0, 4'h4, 0);
    chk(q, 32'h48);
    wb(0, 4'h0, 0);
    chk(q, 32'h01);
    chk(pri_osc_en_o, 0);
    pri_ready_i <= 0;
    wb(1, 4'h0, 32'h02);
    repeat (60) @(posedge clk_i);
    chk({gates, pri_osc_en_o}, 4'h5);
    pri_ready_i <= 1;
    wait_gate(3'h4, 4);
    wb(0, 4'h4, 0);
    chk(q, 32'h08);
    chk(sec_osc_en_o, 1);
  endtask
  task t_int;
    wb(1, 4'h8, 32'h01);
    wb(1, 4'h0, 32'h03);
    wait_gate(3'h1, 8);
    wb(0, 4'h0, 0);
    chk(q, 32'h03);
    wb(0, 4'h4, 0);
    chk(q, 32'h08);
    chk(pri_osc_en_o, 0);
    pri_ready_i <= 0;
    wb(1, 4'h0, 32'h02);
    repeat (60) @(posedge clk_i);
    chk(gates, 3'h1);
    pri_ready_i <= 1;
    wait_gate(3'h4, 4);
    wb(0, 4'h0, 0);
    chk(q, 32'h0A);
    chk(lf_osc_en_o, 1);
  endtask
  task t_power;
    wb(1, 4'h0, 32'h82);
    @(posedge clk_i) power_down_i <= 1;
    @(posedge clk_i) power_down_i <= 0;
    repeat (4) @(posedge clk_i);
    chk({cpu_clk_en_o, periph_clk_en_o, gates}, 5'h0C);
    @(posedge clk_i) wake_irq_i <= 1;
    @(posedge clk_i) wake_irq_i <= 0;
    for (n = 0; cpu_clk_en_o !== 1'b1 && n < 100; n++) @(posedge clk_i);
    chk(n >= RDY && n <= RDY + 2, 1);
    limit(100);
    wb(0, 4'h0, 0);
    chk(q, 32'h8A);
    wb(1, 4'h0, 32'h02);
    @(posedge clk_i) power_down_i <= 1;
    @(posedge clk_i) power_down_i <= 0;
    repeat (4) @(posedge clk_i);
    chk({cpu_clk_en_o, periph_clk_en_o, pri_osc_en_o}, 0);
    chk(lf_osc_en_o, 1);
    chk(sec_osc_en_o, 1);
    wb(0, 4'h0, 0);
    chk(q, 32'h02);
    @(posedge clk_i) wdt_timeout_i <= 1;
    @(posedge clk_i) wdt_timeout_i <= 0;
    for (n = 0; cpu_clk_en_o !== 1'b1 && n < 400; n++) @(posedge clk_i);
    limit(400);
    chk(gates, 3'h4);
    wb(0, 4'h0, 0);
    chk(q, 32'h0A);
    // Two-speed wake: internal first, primary once it is ready
    wb(1, 4'h8, 32'h05);
    @(posedge clk_i) power_down_i <= 1;
    @(posedge clk_i) power_down_i <= 0;
    repeat (4) @(posedge clk_i);
    chk(gates, 3'h0);
    @(posedge clk_i) wake_irq_i <= 1;
    @(posedge clk_i) wake_irq_i <= 0;
    repeat (3) @(posedge clk_i);
    chk(gates, 3'h1);
    wb(0, 4'h0, 0);
    chk(q, 32'h02);
    wait_gate(3'h4, 4);
    wb(0, 4'h0, 0);
    chk(q, 32'h0A);
  endtask
  // Main sequence
  initial
  begin
    {failures, samples_checked} = 0;
    {rst_i, pri_ready_i, wb_sel_i, tick_cnt} = {2'h3, 4'hF, 8'h00};
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 0;
    {power_down_i, wake_irq_i, wdt_timeout_i, sec_running_i} = 0;
    {pri_tick_i, sec_tick_i, int_tick_i} = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    t_reset;
    t_sec;
    t_int;
    t_power;
    stop_test;
  end
endmodule // tb
